// ===== bench/dma_addr_regs_assertions.sv
// port-level checks for the dma address register bank
module dma_addr_regs_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [dma_addr_pkg::ADDR_W-1:0] audio_dma_addr,
  input wire logic [dma_addr_pkg::ADDR_W-1:0] keyboard_dma_addr
);
  import dma_addr_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] wd_q;
  logic tk;
  logic mp;
  // accepted word transfer and whether it hits a register
  assign tk = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  assign mp = haddr inside {32'h2C0000B0, 32'h2C0000B8,
    32'h2C0000C0, 32'h2C0000C8};
  // keeps data phase write data for the update check
  always_ff @(posedge hclk) wd_q <= hwdata;
  chk_ready_always: assert property (hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("error response");
  chk_aud_pad: assert property (
    audio_dma_addr[31:21] == 11'h000 && !audio_dma_addr[0])
    else $error("audio address pad bits set");
  chk_key_pad: assert property (
    keyboard_dma_addr[31:21] == 11'h000 && !keyboard_dma_addr[0])
    else $error("keyboard address pad bits set");
  chk_aud_wr: assert property (
    tk && hwrite && haddr == 32'h2C0000B0 |=> ##1
    audio_dma_addr[15:0] == (wd_q[15:0] & LOW_MASK))
    else $error("audio low write lost");
  chk_key_high_wr: assert property (
    tk && hwrite && haddr == 32'h2C0000C8 |=> ##1
    keyboard_dma_addr[20:16] == wd_q[4:0])
    else $error("keyboard high write lost");
  chk_high_rd: assert property (
    tk && !hwrite && haddr inside {32'h2C0000B8, 32'h2C0000C8}
    |=> hrdata[31:5] == 27'h0)
    else $error("high read shows upper bits");
  chk_aud_rd: assert property (
    tk && !hwrite && haddr == 32'h2C0000B0
    |=> hrdata == {16'h0000, audio_dma_addr[15:0]})
    else $error("audio low read mismatch");
  chk_unmap_rd: assert property (
    tk && !hwrite && !mp |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind dma_addr_regs dma_addr_regs_checker chk_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .audio_dma_addr(audio_dma_addr),
  .keyboard_dma_addr(keyboard_dma_addr));

// ===== bench/dma_addr_regs_tb.sv
// self-checking bench for the dma address register bank
module dma_addr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_addr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, aud, key, p;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] ra [4] = '{32'h2C0000B0, 32'h2C0000B8,
    32'h2C0000C0, 32'h2C0000C8};
  logic [15:0] msk [4] = '{16'hFFFE, 16'h001F, 16'hFFFE, 16'h001F};
  logic [15:0] rst [4] = '{16'hE000, 16'h001F, 16'hD800, 16'h001F};
  logic [31:0] pats [3] = '{32'hFFFFFFFF, 32'h00005A5B, 32'h1234ABCD};
  assign hready = hreadyout;
  dma_addr_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .audio_dma_addr(aud),
    .keyboard_dma_addr(key));
  // clock source
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer, entered just after a rising edge
  task automatic xfer(logic [31:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(hrdata, exp);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // reset values of all four registers and both channel addresses
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rd(ra[i], {16'h0, rst[i]});
    check(aud, 32'h001FE000);
    check(key, 32'h001FD800);
    $display("reset value test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (3000) @(posedge hclk);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    do_reset();
    t_reset();
    // physical patterns written and read straight back
    for (int k = 0; k < 3; k++) begin
      p = pats[k];
      for (int i = 0; i < 4; i++) begin
        xfer(ra[i], 1'b1, p);
        rd(ra[i], p & {16'h0, msk[i]});
      end
      check(aud, {11'h0, p[4:0], p[15:1], 1'b0});
      check(key, {11'h0, p[4:0], p[15:1], 1'b0});
    end
    $display("pattern test done");
    // unmapped, unscaled, byte-size and deselected writes change nothing
    xfer(32'h0B00002C, 1'b1, 32'h0);
    xfer(32'h2C0000B4, 1'b1, 32'h0);
    hsize <= 3'b000;
    xfer(ra[0], 1'b1, 32'h0);
    hsize <= HSIZE_WORD;
    // write to audio low with the slave not selected
    hsel <= 1'b0;
    haddr <= ra[0];
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= 32'h0;
    @(posedge hclk);
    rd(32'h2C0000B4, 32'h0);
    rd(32'h0B00002C, 32'h0);
    rd(ra[0], 32'h0000ABCC);
    $display("refused access test done");
    do_reset();
    t_reset();
    tally_and_finish();
  end
endmodule

// ===== design/dma_addr_pkg.sv
// constants and types shared by the dma channel address register bank
//
// How it works
// - audio low bits 15..11 are read/write base address bits 15..11
// - audio low bits 10..1 are read/write offset address bits 10..1
// - audio low bit 0 reads zero; software writes zero there
// - audio high bits 15..5 read zero; software writes zero there
// - audio high bits 4..0 are read/write base address bits 20..16
// - keyboard low bits 15..11 are read/write base address bits 15..11
// - keyboard low bits 10..1 are read/write offset address bits 10..1
// - keyboard low bit 0 reads zero; software writes zero there
// - audio low decoded at index 0x0B00002C, audio high at 0x0B00002E
// - keyboard low decoded at index 0x0B000030
// - keyboard high bits 4..0 hold bits 20..16; bits 15..5 read zero
// - keyboard high decoded at index 0x0B000032, reset value 0x001F
package dma_addr_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] AUD_LOW_IDX = 32'h0B00002C;
  localparam logic [31:0] AUD_HIGH_IDX = 32'h0B00002E;
  localparam logic [31:0] KEY_LOW_IDX = 32'h0B000030;
  localparam logic [31:0] KEY_HIGH_IDX = 32'h0B000032;

  // values after reset
  localparam logic [15:0] AUD_LOW_RESET = 16'hE000;
  localparam logic [15:0] AUD_HIGH_RESET = 16'h001F;
  localparam logic [15:0] KEY_LOW_RESET = 16'hD800;
  localparam logic [15:0] KEY_HIGH_RESET = 16'h001F;

  // writable bits of each half
  localparam logic [15:0] LOW_MASK = 16'hFFFE;
  localparam logic [15:0] HIGH_MASK = 16'h001F;

  // field positions of the channel address
  localparam int HIGH_FIELD_W = 5;
  localparam int ADDR_W = 32;
  localparam int PAD_W = ADDR_W - 16 - HIGH_FIELD_W;

  // channel numbering
  localparam int NUM_CH = 2;
  localparam int CH_AUDIO = 0;
  localparam int CH_KEYBOARD = 1;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  // register selected by an address phase
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_AUD_LOW = 3'b001,
    SEL_AUD_HIGH = 3'b011,
    SEL_KEY_LOW = 3'b010,
    SEL_KEY_HIGH = 3'b110
  } reg_sel_e;

  // bus data phase state
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b11
  } phase_e;

endpackage

// ===== design/dma_addr_regs.sv
// ahb-lite register bank holding the audio and keyboard dma addresses
//
// Added by the designer: the AHB-Lite register port.
module dma_addr_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [dma_addr_pkg::ADDR_W-1:0] audio_dma_addr,
  output logic [dma_addr_pkg::ADDR_W-1:0] keyboard_dma_addr
);
  import dma_addr_pkg::*;

  // address phase qualification
  logic access;
  logic word_access;
  reg_sel_e addr_sel;

  // data phase tracking
  phase_e phase_q;
  phase_e phase_d;
  reg_sel_e sel_q;
  reg_sel_e sel_d;

  // read data and response
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic hreadyout_q;
  logic hresp_q;

  // write strobes and register contents per channel
  logic [NUM_CH-1:0] low_we;
  logic [NUM_CH-1:0] high_we;
  logic [15:0] low_val [NUM_CH];
  logic [15:0] high_val [NUM_CH];

  // values a read must see, including a write still in its data phase
  logic [15:0] low_fwd [NUM_CH];
  logic [15:0] high_fwd [NUM_CH];
  logic [15:0] read_half;

  // byte address of a register index
  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'b00};
  endfunction

  // selection code of a channel's low half
  function automatic reg_sel_e low_sel_of(input int ch);
    low_sel_of = (ch == CH_AUDIO) ? SEL_AUD_LOW : SEL_KEY_LOW;
  endfunction

  // selection code of a channel's high half
  function automatic reg_sel_e high_sel_of(input int ch);
    high_sel_of = (ch == CH_AUDIO) ? SEL_AUD_HIGH : SEL_KEY_HIGH;
  endfunction

  // a transfer is taken when selected, active and the bus is ready
  assign access = hsel && htrans[1] && hready;
  assign word_access = access && (hsize == HSIZE_WORD);

  // address decode at the printed indices
  always_comb begin
    addr_sel = SEL_NONE;
    if (word_access) begin
      if (haddr == byte_addr(AUD_LOW_IDX)) begin
        addr_sel = SEL_AUD_LOW;
      end else if (haddr == byte_addr(AUD_HIGH_IDX)) begin
        addr_sel = SEL_AUD_HIGH;
      end else if (haddr == byte_addr(KEY_LOW_IDX)) begin
        addr_sel = SEL_KEY_LOW;
      end else if (haddr == byte_addr(KEY_HIGH_IDX)) begin
        addr_sel = SEL_KEY_HIGH;
      end else begin
        addr_sel = SEL_NONE; // unmapped: reads zero, writes dropped
      end
    end
  end

  // next data phase: idle, write or read
  always_comb begin
    phase_d = PH_IDLE;
    sel_d = SEL_NONE;
    if (access) begin
      sel_d = addr_sel;
      if (hwrite) begin
        phase_d = PH_WRITE;
      end else begin
        phase_d = PH_READ;
      end
    end
  end

  // register the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= PH_IDLE;
      sel_q <= SEL_NONE;
    end else begin
      phase_q <= phase_d;
      sel_q <= sel_d;
    end
  end

  // write strobes and forwarding, one pass per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam logic [15:0] LR =
        (ch == CH_AUDIO) ? AUD_LOW_RESET : KEY_LOW_RESET;
      localparam logic [15:0] HR =
        (ch == CH_AUDIO) ? AUD_HIGH_RESET : KEY_HIGH_RESET;

      // strobe the half named by the write's address phase
      assign low_we[ch] = (phase_q == PH_WRITE) &&
                          (sel_q == low_sel_of(ch));
      assign high_we[ch] = (phase_q == PH_WRITE) &&
                           (sel_q == high_sel_of(ch));

      // a read right behind a write sees the written value
      assign low_fwd[ch] = low_we[ch] ?
                           (hwdata[15:0] & LOW_MASK) : low_val[ch];
      assign high_fwd[ch] = high_we[ch] ?
                            (hwdata[15:0] & HIGH_MASK) : high_val[ch];

      dma_chan_addr #(
        .LOW_RESET(LR),
        .HIGH_RESET(HR)
      ) u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .low_we(low_we[ch]),
        .high_we(high_we[ch]),
        .wdata(hwdata[15:0]),
        .low_q(low_val[ch]),
        .high_q(high_val[ch])
      );
    end
  endgenerate

  // read mux; reserved bits and the upper half word read zero
  always_comb begin
    read_half = 16'h0000;
    unique case (addr_sel)
      SEL_AUD_LOW: read_half = low_fwd[CH_AUDIO];
      SEL_AUD_HIGH: read_half = high_fwd[CH_AUDIO];
      SEL_KEY_LOW: read_half = low_fwd[CH_KEYBOARD];
      SEL_KEY_HIGH: read_half = high_fwd[CH_KEYBOARD];
      SEL_NONE: read_half = 16'h0000;
    endcase
  end

  // read data is fetched during the address phase and held
  always_comb begin
    hrdata_d = hrdata_q;
    if (access && !hwrite) begin
      hrdata_d = {16'h0000, read_half};
    end
  end

  // bus outputs: no wait states, always an okay response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end else begin
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // channel addresses handed to the dma control logic, taken as stored
  assign audio_dma_addr = {{PAD_W{1'b0}},
    high_val[CH_AUDIO][HIGH_FIELD_W-1:0], low_val[CH_AUDIO]};
  assign keyboard_dma_addr = {{PAD_W{1'b0}},
    high_val[CH_KEYBOARD][HIGH_FIELD_W-1:0],
    low_val[CH_KEYBOARD]};

endmodule

// ===== design/dma_chan_addr.sv
// one dma channel's low and high address register pair
module dma_chan_addr #(
  parameter logic [15:0] LOW_RESET = 16'h0000,
  parameter logic [15:0] HIGH_RESET = 16'h0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic low_we,
  input wire logic high_we,
  input wire logic [15:0] wdata,
  output logic [15:0] low_q,
  output logic [15:0] high_q
);
  import dma_addr_pkg::*;

  logic [15:0] low_d;
  logic [15:0] high_d;

  // next values; read-only bits are forced to zero on every write
  always_comb begin
    low_d = low_q;
    high_d = high_q;
    if (low_we) begin
      low_d = wdata & LOW_MASK;
    end
    if (high_we) begin
      high_d = wdata & HIGH_MASK;
    end
  end

  // register the pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= LOW_RESET;
      high_q <= HIGH_RESET;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

endmodule
